// ### src/bldc_speed_ctrl.sv
// Closed-loop PI speed controller with demand PWM decode and AXI4-Lite registers.
`timescale 1ns/1ps
module bldc_speed_ctrl
  import bldc_speed_pkg::*;
#(
  parameter int unsigned SPEED_GATE_CYCLES = SPEED_GATE_DEF
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        demand_pwm_in,
  input  wire logic        ecycle_pulse,
  input  wire logic        comm_pulse,
  input  wire logic        hold_done,
  input  wire logic        sync_lost,
  input  wire logic        cur_limit_trip,
  output logic             bridge_pwm_out,
  output logic             drive_enable,
  output logic             brake_out,
  output logic             start_seq_run,
  output logic             start_seq_reset,
  output logic             fault_out_n
);

  // ****************************************
  // Register bus
  // ****************************************
  logic [31:0] ctrl_q;
  logic [7:0]  ss_q;
  logic        aw_have_q, w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  state_e      state_q, state_d;
  logic [7:0]  duty_q, speed_q, bridge_duty_q;

  wire         run_en  = ctrl_q[CTRL_RUN];
  wire         brk_en  = ctrl_q[CTRL_BRK];
  wire         rsc_en  = ctrl_q[CTRL_RSC];
  wire [2:0]   max_speed_select     = ctrl_q[CTRL_SMX +: 3];
  wire [4:0]   pw      = ctrl_q[CTRL_PW +: 5];
  wire [2:0]   sp      = ctrl_q[CTRL_SP +: 3];
  wire [2:0]   si      = ctrl_q[CTRL_SI +: 3];
  // Top electrical frequency in units of 0.1 Hz.
  // top frequency
  wire [15:0]  top_electrical_frequency = (16'h0001 << ({1'b0, max_speed_select} + 4'h8)) - 16'h0001;

  wire         wr_fire = aw_have_q & w_have_q & ~bvalid;
  wire         wr_ctrl = wr_fire & (aw_addr_q == REG_CTRL);
  wire         wr_ss   = wr_fire & (aw_addr_q == REG_SPEED) & w_strb_q[0];
  wire         wr_map  = (aw_addr_q == REG_CTRL) | (aw_addr_q == REG_SPEED) |
                         (aw_addr_q == REG_STAT) | (aw_addr_q == REG_TOP_ELECTRICAL_FREQUENCY);
  wire         rd_map  = (araddr == REG_CTRL) | (araddr == REG_SPEED) |
                         (araddr == REG_STAT) | (araddr == REG_TOP_ELECTRICAL_FREQUENCY);
  wire [31:0]  rd_word = (araddr == REG_CTRL)  ? ctrl_q :
                         (araddr == REG_SPEED) ? {24'h000000, ss_q} :
                         (araddr == REG_STAT)  ? {5'h00, state_q, bridge_duty_q,
                                                  speed_q, duty_q} :
                         (araddr == REG_TOP_ELECTRICAL_FREQUENCY)  ? {16'h0000, top_electrical_frequency} :
                                                 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready   <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_map ? RESP_OKAY : RESP_SLV;
      end else if (bvalid && bready) begin
        bvalid    <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end
  end

  for (genvar b = 0; b < 4; b++) begin : g_ctrl
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_q[8*b +: 8] <= CTRL_RESET[8*b +: 8];
      end else if (wr_ctrl && w_strb_q[b]) begin
        ctrl_q[8*b +: 8] <= w_data_q[8*b +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_q <= SS_RESET;
    end else if (wr_ss) begin
      ss_q <= w_data_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_map ? RESP_OKAY : RESP_SLV;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ****************************************
  // Demand input measurement
  // ****************************************
  logic                pwm_prev_q;
  logic [IN_CNT_W-1:0] per_cnt_q, hi_cnt_q, period_q, div_p_q;
  logic [IN_CNT_W+1:0] lo_cnt_q;
  logic [IN_CNT_W:0]   div_r_q;
  logic [8:0]          div_q_q;
  logic [3:0]          div_n_q;

  wire                 in_rise = demand_pwm_in & ~pwm_prev_q;
  wire [IN_CNT_W+1:0]  per_x2  = {1'b0, period_q, 1'b0};
  wire [IN_CNT_W+1:0]  per_x3  = per_x2 + {2'b00, period_q};
  wire                 idle2   = lo_cnt_q > per_x2;
  wire                 idle3   = lo_cnt_q > per_x3;
  wire                 div_ge  = div_r_q >= {1'b0, div_p_q};
  wire [IN_CNT_W:0]    div_sub = div_r_q - {1'b0, div_p_q};
  wire [8:0]           div_qn  = {div_q_q[7:0], div_ge};

  // Counters saturate so a stuck input never wraps into a false short period.
  // full range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_prev_q <= 1'b0;
      per_cnt_q  <= '0;
      hi_cnt_q   <= '0;
      lo_cnt_q   <= '0;
      period_q   <= '0;
    end else begin
      pwm_prev_q <= demand_pwm_in;
      per_cnt_q  <= in_rise ? IN_CNT_W'(1) : per_cnt_q + IN_CNT_W'(~&per_cnt_q);
      hi_cnt_q   <= in_rise ? IN_CNT_W'(1) :
                    hi_cnt_q + IN_CNT_W'(demand_pwm_in & ~&hi_cnt_q);
      lo_cnt_q   <= demand_pwm_in ? '0 : lo_cnt_q + (IN_CNT_W+2)'(~&lo_cnt_q);
      if (in_rise) begin
        period_q <= per_cnt_q;
      end
    end
  end

  // Nine restoring steps give high*256/period; a full-high period gives 256.
  // eight-bit duty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r_q <= '0;
      div_p_q <= '0;
      div_q_q <= 9'h000;
      div_n_q <= 4'h0;
      duty_q  <= 8'h00;
    end else begin
      if (in_rise) begin
        div_r_q <= {1'b0, hi_cnt_q};
        div_p_q <= per_cnt_q;
        div_q_q <= 9'h000;
        div_n_q <= 4'h9;
      end else if (div_n_q != 4'h0) begin
        div_r_q <= div_ge ? {div_sub[IN_CNT_W-1:0], 1'b0} : {div_r_q[IN_CNT_W-1:0], 1'b0};
        div_q_q <= div_qn;
        div_n_q <= div_n_q - 4'h1;
      end
      if (idle2) begin
        duty_q <= 8'h00;
      end else if (div_n_q == 4'h1 && !in_rise) begin
        duty_q <= div_qn[8] ? 8'hff : div_qn[7:0];
      end
    end
  end

  // ****************************************
  // Speed measurement and PI loop
  // ****************************************
  logic [28:0] gate_cnt_q;
  logic [7:0]  ecnt_q;
  logic        gate_end_q;
  logic [15:0] integ_q;

  wire [28:0]  gate_len = 29'(SPEED_GATE_CYCLES >> max_speed_select);
  wire         gate_hit = gate_cnt_q >= gate_len - 29'd1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt_q <= '0;
      ecnt_q     <= 8'h00;
      speed_q    <= 8'h00;
      gate_end_q <= 1'b0;
    end else begin
      gate_end_q <= gate_hit;
      gate_cnt_q <= gate_hit ? '0 : gate_cnt_q + 29'd1;
      if (gate_hit) begin
        speed_q <= ecnt_q;
        ecnt_q  <= {7'h00, ecycle_pulse};
      end else begin
        ecnt_q  <= ecnt_q + {7'h00, ecycle_pulse & ~&ecnt_q};
      end
    end
  end

  // Both speed and demand are fractions of the top frequency over 255.
  // demand reference
  wire signed [23:0] err   = $signed({16'h0000, duty_q}) - $signed({16'h0000, speed_q});
  wire signed [23:0] i_sum = $signed({8'h00, integ_q}) + (err <<< si);
  wire [15:0]        i_sat = i_sum[23] ? 16'h0000 :
                             (i_sum > 24'sh00ffff) ? 16'hffff : i_sum[15:0];
  wire signed [23:0] o_sum = $signed({8'h00, i_sat}) + (err <<< ({1'b0, sp} + 4'h4));
  wire [15:0]        o_sat = o_sum[23] ? 16'h0000 :
                             (o_sum > 24'sh00ffff) ? 16'hffff : o_sum[15:0];

  // The integrator is preloaded with the start duty for a smooth handover.
  // PI update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integ_q       <= 16'h0000;
      bridge_duty_q <= 8'h00;
    end else if (state_q != st_run) begin
      integ_q       <= {START_DUTY, 8'h00};
    end else if (gate_end_q) begin
      integ_q       <= i_sat;
      bridge_duty_q <= o_sat[15:8];
    end
  end

  // ****************************************
  // Bridge PWM and current limit
  // ****************************************
  logic [10:0] pw_cnt_q, off_cnt_q;

  wire [10:0]  br_period = ({6'h00, pw} + 11'h001) * BR_STEP;
  wire         st_drive  = (state_q == st_start) | (state_q == st_run);
  wire [7:0]   duty_eff  = (state_q == st_start) ? START_DUTY :
                           (state_q == st_run)   ? bridge_duty_q : 8'h00;
  wire [18:0]  on_lim    = {11'h000, duty_eff} * {8'h00, br_period};
  wire         pwm_on    = st_drive & ~idle2 & (off_cnt_q == 11'h000) &
                           ((duty_eff == 8'hff) | ({pw_cnt_q, 8'h00} < on_lim));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_cnt_q  <= 11'h000;
      off_cnt_q <= 11'h000;
    end else begin
      pw_cnt_q <= (pw_cnt_q >= br_period - 11'h001) ? 11'h000 : pw_cnt_q + 11'h001;
      if (cur_limit_trip && bridge_pwm_out && off_cnt_q == 11'h000) begin
        off_cnt_q <= br_period;
      end else if (off_cnt_q != 11'h000) begin
        off_cnt_q <= off_cnt_q - 11'h001;
      end
    end
  end

  // ****************************************
  // Motor state sequencing
  // ****************************************
  logic       hold_seen_q;
  logic [1:0] comm_cnt_q;
  logic [3:0] los_per_q;

  wire [7:0]  ss_thr     = {2'b00, ss_q[7:2]};
  wire        duty_hi    = duty_q > DUTY_25;
  wire        brk_go     = brk_en & idle3 & (duty_q <= DUTY_10);
  wire        start_done = comm_cnt_q == START_COMM;
  wire        low_spd    = gate_end_q & ((speed_q < ss_thr) | (duty_q < ss_thr));
  wire        los_wrap   = in_rise & (los_per_q == LOS_LAST);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_idle: begin
        if (run_en) begin
          state_d = (brk_en && duty_q <= DUTY_10) ? st_brake : st_coast;
        end
      end
      st_brake: begin
        if (!run_en) state_d = st_idle;
        else if (!brk_en) state_d = st_coast;
        else if (duty_hi) state_d = st_start;
        else if (duty_q > DUTY_10) state_d = st_coast;
      end
      st_coast: begin
        if (!run_en) state_d = st_idle;
        else if (duty_hi) state_d = st_start;
        else if (brk_go) state_d = st_brake;
      end
      st_start: begin
        if (!run_en) state_d = st_idle;
        else if (idle2) state_d = brk_en ? st_brake : st_coast;
        else if (start_done) state_d = st_run;
      end
      st_run: begin
        if (!run_en) state_d = st_idle;
        else if (brk_go) state_d = st_brake;
        else if (!idle2 && (low_spd || sync_lost)) state_d = st_los;
      end
      st_los: begin
        if (!run_en || !duty_hi) state_d = st_coast;
        else if (rsc_en && los_wrap) state_d = st_start;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= st_idle;
      hold_seen_q <= 1'b0;
      comm_cnt_q  <= 2'h0;
      los_per_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      if (state_q != st_start || sync_lost) begin
        hold_seen_q <= 1'b0;
        comm_cnt_q  <= 2'h0;
      end else begin
        hold_seen_q <= hold_seen_q | hold_done;
        if (hold_seen_q && comm_pulse && !start_done) begin
          comm_cnt_q <= comm_cnt_q + 2'h1;
        end
      end
      if (state_q != st_los) los_per_q <= 4'h0;
      else if (los_wrap) los_per_q <= 4'h0;
      else if (in_rise) los_per_q <= los_per_q + 4'h1;
    end
  end

  wire fault_low = (state_q == st_los) &
                   ((los_per_q < FLT_LOW0) | ((los_per_q >= FLT_HIGH0) & (los_per_q < FLT_LOW1)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bridge_pwm_out  <= 1'b0;
      drive_enable    <= 1'b0;
      brake_out       <= 1'b0;
      start_seq_run   <= 1'b0;
      start_seq_reset <= 1'b0;
      fault_out_n     <= 1'b1;
    end else begin
      bridge_pwm_out  <= pwm_on;
      drive_enable    <= st_drive;
      brake_out       <= state_q == st_brake;
      start_seq_run   <= (state_d == st_start) | (state_d == st_run);
      start_seq_reset <= ((state_q != st_start) & (state_d == st_start)) |
                         ((state_q == st_start) & (state_d == st_start) & sync_lost);
      fault_out_n     <= ~fault_low;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_brake_needs_en: assert property (
    brake_out |-> $past(brk_en, 2)) else $error("brake without brake enable");
  chk_stop_coasts: assert property (
    !run_en |-> ##2 !drive_enable) else $error("drive kept after run cleared");
  chk_idle_pwm_off: assert property (
    idle2 |=> !bridge_pwm_out) else $error("bridge pwm on while input idle");
  chk_fault_in_los: assert property (
    !fault_out_n |-> $past(state_q) == st_los) else $error("fault outside loss state");
  chk_start_duty_held: assert property (
    (state_q == st_start && $past(state_q) == st_start) |-> $stable(bridge_duty_q))
    else $error("demand used during start");
  chk_trip_off_time: assert property (
    (cur_limit_trip && bridge_pwm_out && off_cnt_q == 11'h000) |=> ##1 !bridge_pwm_out [*8])
    else $error("bridge on inside off-time");
  chk_brake_low_duty: assert property (
    $rose(brake_out) |-> ($past(duty_q, 2) <= DUTY_10) || $past(idle2, 2))
    else $error("brake with duty above 10");
  chk_start_entry: assert property (
    (state_q != st_start && state_d == st_start) |=> start_seq_reset && start_seq_run)
    else $error("start entry not signalled");

  cov_brake: cover property ($rose(brake_out));
  cov_run: cover property (state_q == st_start ##1 state_q == st_run);
  cov_restart: cover property (state_q == st_los ##1 state_q == st_start);
  cov_trip: cover property (cur_limit_trip && bridge_pwm_out);

endmodule

// ### src/bldc_speed_pkg.sv
// Constants and types for the closed-loop BLDC speed controller.
// Notes on behaviour
// - Top frequency is 0.1*(2^(sel+8)-1) Hz.
// - Demand is input duty times top frequency.
// - PI compares demand with speed, sets duty.
// - Bridge PWM period comes from period select.
// - Current trip forces off for one period.
// - Proportional and integral gains set independently.
// - Input PWM measured anywhere from 5 Hz-1 kHz.
// - Idle over twice period turns PWM off.
// - One more idle period brakes if enabled.
// - After reset or enable, brake until duty>10%.
// - Brake enable cleared means never brake.
// - Brake only from zero duty below 10%.
// - After brake, 10-25% duty makes motor coast.
// - Duty above 25% starts the start sequence.
// - Ignore demand until two commutations after hold.
// - Idle input during start aborts into brake, or into coast if brake is not enabled.
// - Below quarter start speed, all bridge off.
// - Loss of sync: fault low 3, high 3.
// - Restart enabled: two patterns, then restart, repeat.
// - No restart: fault until duty<25% or stop.
// - Failed start keeps repeating the start sequence.
// - Input duty measured with 8-bit resolution.
package bldc_speed_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned PWM_IN_MIN_HZ  = 5;
  localparam int unsigned IN_PER_MAX_CYC = CLK_HZ / PWM_IN_MIN_HZ;
  localparam int unsigned IN_CNT_W       = $clog2(IN_PER_MAX_CYC + 1);
  // Speed gate: full-scale count of 255 at the top frequency.
  localparam int unsigned SPEED_GATE_S   = 10;
  localparam int unsigned SPEED_GATE_DEF = CLK_HZ * SPEED_GATE_S;
  localparam int unsigned PW_STEP_NS     = 1000;
  localparam int unsigned PW_STEP_CYC    = (PW_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [10:0] BR_STEP        = 11'(PW_STEP_CYC);

  // ****************************************
  // Thresholds and sequences
  // ****************************************
  localparam logic [7:0] DUTY_10     = 8'h19;
  localparam logic [7:0] DUTY_25     = 8'h40;
  localparam logic [7:0] START_DUTY  = 8'h80;
  localparam logic [1:0] START_COMM  = 2'h2;
  localparam logic [3:0] FLT_LOW0    = 4'h3;
  localparam logic [3:0] FLT_HIGH0   = 4'h6;
  localparam logic [3:0] FLT_LOW1    = 4'h9;
  localparam logic [3:0] LOS_LAST    = 4'hb;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_SPEED  = 8'h04;
  localparam logic [7:0]  REG_STAT   = 8'h08;
  localparam logic [7:0]  REG_TOP_ELECTRICAL_FREQUENCY   = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  localparam logic [7:0]  SS_RESET   = 8'h40;
  localparam int unsigned CTRL_RUN   = 0;
  localparam int unsigned CTRL_BRK   = 1;
  localparam int unsigned CTRL_RSC   = 2;
  localparam int unsigned CTRL_SMX   = 3;
  localparam int unsigned CTRL_PW    = 6;
  localparam int unsigned CTRL_SP    = 11;
  localparam int unsigned CTRL_SI    = 14;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  typedef enum logic [2:0] {
    st_idle, st_brake, st_coast, st_start, st_run, st_los
  } state_e;

endpackage

// ### tb/bldc_closed_loop_speed_control_test.sv
// Self-checking bench for the closed-loop BLDC speed controller.
`timescale 1ns/1ps
module bldc_closed_loop_speed_control_test
  import bldc_speed_pkg::*;
;
  typedef struct packed {logic [31:0] mask; logic [1:0] resp; logic [31:0] data;} note_s;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, ctrl;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        demand_pwm_in, src_run, ecycle_pulse, cur_limit_trip, snap;
  logic [2:0]  ev;
  logic [15:0] high_cyc, cyc;
  logic        bridge_pwm_out, drive_enable, brake_out, start_seq_run, start_seq_reset;
  logic        fault_out_n;
  logic [4:0]  outs;
  note_s       bus_q[$];
  logic [9:0]  out_q[$];
  int          err_count, n_compared, i;
  int          seed = 52;

  assign outs = {bridge_pwm_out, drive_enable, brake_out, start_seq_run, fault_out_n};

  bldc_speed_ctrl #(.SPEED_GATE_CYCLES(2000)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .demand_pwm_in, .ecycle_pulse, .comm_pulse(ev[1]), .hold_done(ev[2]),
    .sync_lost(ev[0]), .cur_limit_trip, .bridge_pwm_out, .drive_enable, .brake_out,
    .start_seq_run, .start_seq_reset, .fault_out_n
  );

  demand_pwm_source ecu (
    .aclk, .run(src_run), .period_cyc(16'd400), .high_cyc, .pwm(demand_pwm_in)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic give_up;
    err_count++;
    final_report();
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bus_q.push_back('{32'h0, r, 32'h0});
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) give_up();
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] r);
    int n;
    bus_q.push_back('{m, r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) give_up();
  endtask

  task automatic chk_state(input state_e s);
    bus_rd(REG_STAT, {5'h0, s, 24'h0}, 32'h0700_0000, RESP_OKAY);
  endtask

  task automatic expect_out(input logic [4:0] m, input logic [4:0] v);
    out_q.push_back({m, v});
    snap <= 1'b1;
    @(posedge aclk);
    snap <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_level(input logic v);
    int n;
    for (n = 0; n < 2000 && demand_pwm_in !== v; n++)
      @(posedge aclk);
    if (n == 2000) give_up();
  endtask

  task automatic fire(input logic [2:0] e);
    ev <= e;
    @(posedge aclk);
    ev <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic cmp_bus(input logic [33:0] got);
    note_s e;
    e = bus_q.pop_front();
    n_compared++;
    if ({got[33:32], got[31:0] & e.mask} !== {e.resp, e.data & e.mask}) begin
      err_count++;
      $display("unexpected bus result at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic cmp_out(input logic [4:0] got);
    logic [9:0] e;
    e = out_q.pop_front();
    n_compared++;
    if ((got & e[9:5]) !== e[4:0]) begin
      err_count++;
      $display("unexpected outputs at %0t: got %h expected %h", $time, got, e[4:0]);
    end
  endtask

  always @(posedge aclk) begin
    if (bvalid && bready) cmp_bus({bresp, 32'h0});
    if (rvalid && rready) cmp_bus({rresp, rdata});
    if (snap) cmp_out(outs);
  end

  // Speed feedback stays well above the low-speed threshold; trips land at random.
  always @(posedge aclk) begin
    cyc            <= cyc + 16'h0001;
    ecycle_pulse   <= (cyc[2:0] == 3'h0);
    cur_limit_trip <= ($random(seed) & 63) == 0;
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, src_run, snap} = 8'h00;
    {awaddr, araddr, wdata, ev, high_cyc, cyc} = '0;
    {ecycle_pulse, cur_limit_trip} = 2'h0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus_rd(REG_CTRL, CTRL_RESET, 32'hffff_ffff, RESP_OKAY);
    bus_rd(REG_SPEED, {24'h0, SS_RESET}, 32'h0000_00ff, RESP_OKAY);
    bus_rd(8'h10, 32'h0, 32'hffff_ffff, RESP_SLV);
    bus_wr(8'h10, 32'h5a5a_5a5a, RESP_SLV);
    for (i = 0; i < 8; i++) begin
      ctrl = ($random(seed) & 32'h0001_ffc0) | (i << 3) | 32'h3;
      bus_wr(REG_CTRL, ctrl, RESP_OKAY);
      bus_rd(REG_CTRL, ctrl, 32'h0001_ffff, RESP_OKAY);
      bus_rd(REG_TOP_ELECTRICAL_FREQUENCY, (32'h1 << (i + 8)) - 32'h1, 32'h0000_ffff, RESP_OKAY);
    end
    bus_wr(REG_CTRL, 32'h7, RESP_OKAY);
    chk_state(st_brake);
    expect_out(5'h06, 5'h04);
    high_cyc <= 16'd80;
    src_run  <= 1'b1;
    repeat (1300) @(posedge aclk);
    bus_rd(REG_STAT, {5'h0, st_coast, 16'h0, 8'((80 * 256) / 400)}, 32'h0700_00ff,
           RESP_OKAY);
    expect_out(5'h0e, 5'h00);
    high_cyc <= 16'd300;
    repeat (1300) @(posedge aclk);
    // The loop output stays at its reset value while the start duty drives the bridge.
    bus_rd(REG_STAT, {5'h0, st_start, 8'h00, 8'h0, 8'((300 * 256) / 400)},
           32'h07ff_00ff, RESP_OKAY);
    expect_out(5'h02, 5'h02);
    src_run <= 1'b0;
    wait_level(1'b0);
    repeat (900) @(posedge aclk);
    // An idle input during start aborts straight into brake at twice the period.
    expect_out(5'h14, 5'h04);
    repeat (500) @(posedge aclk);
    expect_out(5'h04, 5'h04);
    chk_state(st_brake);
    src_run <= 1'b1;
    repeat (1300) @(posedge aclk);
    fire(3'h4);
    fire(3'h2);
    chk_state(st_start);
    fire(3'h2);
    chk_state(st_run);
    // Align the loss with an input rise so rise counting starts cleanly.
    wait_level(1'b0);
    wait_level(1'b1);
    fire(3'h1);
    for (i = 0; i < 12; i++) begin
      if (i > 0) begin
        wait_level(1'b0);
        wait_level(1'b1);
      end
      repeat (150) @(posedge aclk);
      expect_out(5'h09, 5'(((i / 3) % 2)));
    end
    wait_level(1'b0);
    wait_level(1'b1);
    repeat (10) @(posedge aclk);
    expect_out(5'h02, 5'h02);
    chk_state(st_start);
    bus_wr(REG_CTRL, 32'h5, RESP_OKAY);
    src_run <= 1'b0;
    wait_level(1'b0);
    repeat (1600) @(posedge aclk);
    expect_out(5'h04, 5'h00);
    final_report();
  end

  initial begin
    repeat (60000) @(posedge aclk);
    give_up();
  end
endmodule

// ### tb/demand_pwm_source.sv
// Behavioural external control unit driving the demand PWM line.
`timescale 1ns/1ps
module demand_pwm_source (
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic [15:0] period_cyc,
  input  wire logic [15:0] high_cyc,
  output logic             pwm
);
  logic [15:0] cnt_q;
  initial cnt_q = 16'h0000;
  initial pwm = 1'b0;
  // fixed period source
  // The period is much shorter than the slowest legal rate to keep the run short.
  // The duty decode is a ratio, so only the top of its counter range goes unexercised.
  always @(posedge aclk) begin
    cnt_q <= (!run || cnt_q >= period_cyc - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    pwm   <= run && (cnt_q < high_cyc);
  end
endmodule
